// >>> hdl/uva_sequencer.v
// Card supply class selection and activation sequencer
`default_nettype none
`include "uva_map.vh"

// Notes on behaviour
// - The card clock is made here by dividing the system clock to a rate between 1 and 5 MHz.
// - A class is chosen and its supply switched on and settled before clock or reset moves.
// - A newly presented card is first tried at the lowest voltage class the terminal has.
// - With no answer in time the card is switched off and retried one class higher if available.
// - An answer at the applied class is examined, including its supported class flags.
// - If the card lacks the applied class it is switched off and retried once at a class it reports that the terminal also has.
// - A corrupted answer leads to a retry at the same class until three in a row have failed.
// - After three corrupted answers only the immediately next higher class may be tried.
module uva_sequencer #(
    parameter integer NUM_CLASSES    = `UVA_NUM_CLASSES,
    parameter integer RST_LOW_CYCLES = `UVA_RST_LOW_CYCLES,
    parameter integer ATR_WAIT_CYCLES = `UVA_ATR_WAIT_CYCLES
) (
    input  wire                   CLK_SYS,
    input  wire                   ARST_N,
    input  wire                   CARD_PRESENT,
    input  wire [NUM_CLASSES-1:0] TERM_CLASSES,
    input  wire                   ATR_DONE,
    input  wire                   ATR_CORRUPT,
    input  wire [NUM_CLASSES-1:0] ATR_CLASSES,
    output reg                    CARD_VCC_EN,
    output reg  [NUM_CLASSES-1:0] CARD_CLASS,
    output reg                    CARD_RST_N,
    output reg                    CARD_CLK,
    output reg                    ATR_ARM,
    output reg                    SESSION_READY,
    output reg                    CARD_REJECTED
);

    localparam [2:0] S_IDLE   = 3'h0;
    localparam [2:0] S_POWER  = 3'h1;
    localparam [2:0] S_RESET  = 3'h2;
    localparam [2:0] S_WAIT   = 3'h3;
    localparam [2:0] S_DEACT  = 3'h4;
    localparam [2:0] S_READY  = 3'h5;
    localparam [2:0] S_REJECT = 3'h6;

    localparam [31:0] HALF_CYCLES   = `UVA_CARD_HALF_CYCLES;
    localparam [31:0] SETTLE_CYCLES = `UVA_VCC_SETTLE_CYCLES;
    localparam [31:0] DEACT_CYCLES  = `UVA_DEACT_CYCLES;
    localparam [31:0] RST_CYCLES    = RST_LOW_CYCLES;
    localparam [31:0] WAIT_CYCLES   = ATR_WAIT_CYCLES;
    localparam [31:0] CORRUPT_LIMIT = `UVA_CORRUPT_LIMIT;
    localparam [1:0]  CORRUPT_LAST  = CORRUPT_LIMIT[1:0] - 2'h1;

    reg        present_meta;
    reg        present;
    reg [2:0]  state;
    reg [31:0] timer;
    reg [2:0]  cls;
    reg [1:0]  corrupt_cnt;
    reg        bumped;
    reg        switched;
    reg        reject_pend;
    reg [31:0] div_cnt;

    reg        term_any;
    reg [2:0]  term_low;
    reg        pick_any;
    reg [2:0]  pick_low;
    reg        up_ok;
    reg [2:0]  up_cls;
    integer    i;

    wire timer_done = (timer == 32'h0000_0000);
    wire clk_run    = (state == S_RESET) || (state == S_WAIT) || (state == S_READY);

    // Card presence comes from a switch pin
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            present_meta <= 1'b0;
            present      <= 1'b0;
        end else begin
            present_meta <= CARD_PRESENT;
            present      <= present_meta;
        end
    end

    // Class D and E lie below C in voltage, so a higher index is a lower class voltage
    always @* begin
        term_any = 1'b0;
        term_low = 3'h0;
        pick_any = 1'b0;
        pick_low = 3'h0;
        for (i = 0; i < NUM_CLASSES; i = i + 1) begin
            if (TERM_CLASSES[i]) begin
                term_any = 1'b1;
                term_low = i[2:0];
            end
            if (TERM_CLASSES[i] && ATR_CLASSES[i]) begin
                pick_any = 1'b1;
                pick_low = i[2:0];
            end
        end
        up_cls = cls - 3'h1;
        up_ok  = (cls != 3'h0) && TERM_CLASSES[up_cls];
    end

    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state       <= S_IDLE;
            timer       <= 32'h0000_0000;
            cls         <= 3'h0;
            corrupt_cnt <= 2'h0;
            bumped      <= 1'b0;
            switched    <= 1'b0;
            reject_pend <= 1'b0;
        end else if (!present) begin
            state       <= S_IDLE;
            timer       <= 32'h0000_0000;
            reject_pend <= 1'b0;
        end else begin
            if (!timer_done) begin
                timer <= timer - 32'h0000_0001;
            end
            case (state)
                S_IDLE: begin
                    cls         <= term_low;
                    corrupt_cnt <= 2'h0;
                    bumped      <= 1'b0;
                    switched    <= 1'b0;
                    if (term_any) begin
                        state <= S_POWER;
                        timer <= SETTLE_CYCLES;
                    end else begin
                        state <= S_REJECT;
                    end
                end
                S_POWER: begin
                    // Clock and reset stay idle until the supply has settled
                    if (timer_done) begin
                        state <= S_RESET;
                        timer <= RST_CYCLES;
                    end
                end
                S_RESET: begin
                    if (timer_done) begin
                        state <= S_WAIT;
                        timer <= WAIT_CYCLES;
                    end
                end
                S_WAIT: begin
                    if (ATR_DONE && !ATR_CORRUPT) begin
                        if (ATR_CLASSES[cls]) begin
                            state <= S_READY;
                        end else begin
                            // Only one switch to a reported class, so a contradictory card ends
                            state <= S_DEACT;
                            timer <= DEACT_CYCLES;
                            if (pick_any && !switched) begin
                                cls         <= pick_low;
                                switched    <= 1'b1;
                                corrupt_cnt <= 2'h0;
                            end else begin
                                reject_pend <= 1'b1;
                            end
                        end
                    end else if (ATR_DONE) begin
                        state <= S_DEACT;
                        timer <= DEACT_CYCLES;
                        if (corrupt_cnt != CORRUPT_LAST) begin
                            corrupt_cnt <= corrupt_cnt + 2'h1;
                        end else if (up_ok && !bumped) begin
                            cls         <= up_cls;
                            bumped      <= 1'b1;
                            corrupt_cnt <= 2'h0;
                        end else begin
                            reject_pend <= 1'b1;
                        end
                    end else if (timer_done) begin
                        state <= S_DEACT;
                        timer <= DEACT_CYCLES;
                        if (up_ok) begin
                            cls         <= up_cls;
                            corrupt_cnt <= 2'h0;
                        end else begin
                            reject_pend <= 1'b1;
                        end
                    end
                end
                S_DEACT: begin
                    if (timer_done) begin
                        if (reject_pend) begin
                            state <= S_REJECT;
                        end else begin
                            state <= S_POWER;
                            timer <= SETTLE_CYCLES;
                        end
                    end
                end
                S_READY: begin
                    state <= S_READY;
                end
                S_REJECT: begin
                    state <= S_REJECT;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Contact drive follows the state one cycle later, all from flops
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            CARD_VCC_EN   <= 1'b0;
            CARD_CLASS    <= {NUM_CLASSES{1'b0}};
            CARD_RST_N    <= 1'b0;
            ATR_ARM       <= 1'b0;
            SESSION_READY <= 1'b0;
            CARD_REJECTED <= 1'b0;
        end else begin
            CARD_VCC_EN   <= (state == S_POWER) || clk_run;
            CARD_CLASS    <= ((state == S_POWER) || clk_run) ?
                             ({{(NUM_CLASSES-1){1'b0}}, 1'b1} << cls) : {NUM_CLASSES{1'b0}};
            CARD_RST_N    <= (state == S_WAIT) || (state == S_READY);
            ATR_ARM       <= (state == S_WAIT);
            SESSION_READY <= (state == S_READY);
            CARD_REJECTED <= (state == S_REJECT);
        end
    end

    // The terminal always sources the card clock; it stops low while the card is off
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            div_cnt  <= 32'h0000_0000;
            CARD_CLK <= 1'b0;
        end else if (!clk_run) begin
            div_cnt  <= 32'h0000_0000;
            CARD_CLK <= 1'b0;
        end else if (div_cnt == HALF_CYCLES - 32'h0000_0001) begin
            div_cnt  <= 32'h0000_0000;
            CARD_CLK <= ~CARD_CLK;
        end else begin
            div_cnt  <= div_cnt + 32'h0000_0001;
        end
    end

endmodule // uva_sequencer
`default_nettype wire

// >>> include/uva_map.vh
// Timing figures and field layout for the card voltage class activation sequencer
`ifndef UVA_MAP_VH
`define UVA_MAP_VH

// System clock rate
`define UVA_SYS_CLK_HZ        250000000
`define UVA_SYS_CLK_MHZ       250

// Card clock target; must stay within 1 MHz to 5 MHz
`define UVA_CARD_CLK_HZ       4000000
`define UVA_CARD_CLK_MIN_HZ   1000000
`define UVA_CARD_CLK_MAX_HZ   5000000

// Half period of the card clock in system cycles, rounded up so the rate never exceeds the target
`define UVA_CARD_HALF_CYCLES  ((`UVA_SYS_CLK_HZ + 2 * `UVA_CARD_CLK_HZ - 1) / (2 * `UVA_CARD_CLK_HZ))

// Supply settle time after switching a class on, least time
`define UVA_VCC_SETTLE_NS     1000
`define UVA_VCC_SETTLE_CYCLES ((`UVA_VCC_SETTLE_NS * `UVA_SYS_CLK_MHZ + 999) / 1000)

// Time with all contacts off before a new activation, least time
`define UVA_DEACT_NS          1000
`define UVA_DEACT_CYCLES      ((`UVA_DEACT_NS * `UVA_SYS_CLK_MHZ + 999) / 1000)

// Reset low time and answer wait time, counted in card clock periods
`define UVA_RST_LOW_CARDCLK   400
`define UVA_ATR_WAIT_CARDCLK  40000
`define UVA_RST_LOW_CYCLES    (`UVA_RST_LOW_CARDCLK * 2 * `UVA_CARD_HALF_CYCLES)
`define UVA_ATR_WAIT_CYCLES   (`UVA_ATR_WAIT_CARDCLK * 2 * `UVA_CARD_HALF_CYCLES)

// Consecutive corrupted answers tolerated at one class
`define UVA_CORRUPT_LIMIT     3

// Supply class flag positions in the answer byte and in the terminal capability mask
`define UVA_NUM_CLASSES       5
`define UVA_CLASS_A           0
`define UVA_CLASS_B           1
`define UVA_CLASS_C           2
`define UVA_CLASS_D           3
`define UVA_CLASS_E           4

`endif

// >>> verification/uva_seq_sva.sv
// Port checks for the class activation sequencer
`default_nettype none
module uva_seq_sva #(parameter int NUM_CLASSES = 5) (
    input wire logic                   CLK_SYS,
    input wire logic                   ARST_N,
    input wire logic                   CARD_PRESENT,
    input wire logic [NUM_CLASSES-1:0] TERM_CLASSES,
    input wire logic                   ATR_DONE,
    input wire logic                   ATR_CORRUPT,
    input wire logic [NUM_CLASSES-1:0] ATR_CLASSES,
    input wire logic                   CARD_VCC_EN,
    input wire logic [NUM_CLASSES-1:0] CARD_CLASS,
    input wire logic                   CARD_RST_N,
    input wire logic                   CARD_CLK,
    input wire logic                   ATR_ARM,
    input wire logic                   SESSION_READY,
    input wire logic                   CARD_REJECTED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    chk_class_code: assert property (CARD_VCC_EN ? $onehot(CARD_CLASS) : !CARD_CLASS)
        else $error("class code bad");
    chk_class_term: assert property (CARD_VCC_EN |-> !(CARD_CLASS & ~TERM_CLASSES))
        else $error("class not offered");
    chk_power_first: assert property ($rose(CARD_VCC_EN) |-> (!CARD_CLK && !CARD_RST_N)[*8])
        else $error("activity before settle");
    chk_class_held: assert property (CARD_VCC_EN && $past(CARD_VCC_EN) |-> $stable(CARD_CLASS))
        else $error("class changed while powered");
    // A deactivation may cut a clock half short, so the check stands down with the supply
    chk_clk_rate: assert property (disable iff (!ARST_N || !CARD_VCC_EN)
        $rose(CARD_CLK) |-> ##24 CARD_CLK ##[1:101] !CARD_CLK) else $error("card clock rate");
    chk_ready_cause: assert property ($rose(SESSION_READY) |-> $past(ATR_DONE, 2)
        && !$past(ATR_CORRUPT, 2) && ($past(ATR_CLASSES, 2) & CARD_CLASS)) else $error("ready bad");
    chk_reject_off: assert property (CARD_REJECTED |-> !CARD_VCC_EN && !CARD_CLK && !ATR_ARM)
        else $error("rejected card powered");
    chk_arm_reset: assert property ($rose(CARD_RST_N) |-> ATR_ARM && CARD_VCC_EN)
        else $error("reset release without wait");
    cover property ($rose(SESSION_READY));
    cover property ($rose(CARD_REJECTED));
    cover property (ATR_DONE && ATR_CORRUPT);
endmodule // uva_seq_sva
bind uva_sequencer uva_seq_sva #(.NUM_CLASSES(NUM_CLASSES)) u_sva (.CLK_SYS(CLK_SYS),
    .ARST_N(ARST_N), .CARD_PRESENT(CARD_PRESENT), .TERM_CLASSES(TERM_CLASSES), .ATR_DONE(ATR_DONE),
    .ATR_CORRUPT(ATR_CORRUPT), .ATR_CLASSES(ATR_CLASSES), .CARD_VCC_EN(CARD_VCC_EN),
    .CARD_CLASS(CARD_CLASS), .CARD_RST_N(CARD_RST_N), .CARD_CLK(CARD_CLK), .ATR_ARM(ATR_ARM),
    .SESSION_READY(SESSION_READY), .CARD_REJECTED(CARD_REJECTED));
`default_nettype wire

// >>> verification/uva_card_model.sv
// Behavioural card answering each reset at an unmuted class with its class flags
`default_nettype none
module uva_card_model (
    input  wire logic       clk_sys,
    input  wire logic       present,
    input  wire logic       slow,
    input  wire logic       arm,
    input  wire logic [4:0] card_class,
    input  wire logic [4:0] caps,
    input  wire logic [4:0] mute,
    input  var  int         corrupt_n,
    output var  logic       atr_done,
    output var  logic       atr_corrupt,
    output var  logic [4:0] atr_classes
);
    timeunit 1ns;
    timeprecision 1ps;
    int   wait_cnt = 0;
    int   answers = 0;
    logic arm_q = 1'b0;
    always @(posedge clk_sys) begin
        arm_q <= arm;
        atr_done <= 1'b0;
        atr_corrupt <= 1'b0;
        atr_classes <= 5'($urandom); // Invalid outside an answer, so never left steady
        wait_cnt <= (arm && !arm_q) ? (slow ? 120 : 3) : (wait_cnt > 0 ? wait_cnt - 1 : 0);
        if (!present)
            answers <= 0;
        if (wait_cnt == 1 && arm && !(card_class & mute)) begin
            atr_done <= 1'b1;
            atr_corrupt <= answers < corrupt_n;
            atr_classes <= caps;
            answers <= answers + 1;
        end
    end
endmodule // uva_card_model
`default_nettype wire

// >>> verification/tb_uva_sequencer.sv
// Self-checking bench for the class activation sequencer
`default_nettype none
module tb_uva_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0, arst_n = 1'b0, present = 1'b0, slow = 1'b0, vcc_q = 1'b0;
    logic [4:0] term = 5'h00, caps = 5'h00, mute = 5'h00, atr_cls, card_class;
    logic       done, corrupt, vcc_en, rst_n, card_clk, arm, ready, rejected, exp_ready;
    int         corrupt_n = 0, bad_count = 0, check_count = 0, cycles = 0, exp_q[$];
    uva_sequencer #(.RST_LOW_CYCLES(64), .ATR_WAIT_CYCLES(500)) dut (.CLK_SYS(clk_sys),
        .ARST_N(arst_n), .CARD_PRESENT(present), .TERM_CLASSES(term), .ATR_DONE(done),
        .ATR_CORRUPT(corrupt), .ATR_CLASSES(atr_cls), .CARD_VCC_EN(vcc_en), .CARD_CLASS(card_class),
        .CARD_RST_N(rst_n), .CARD_CLK(card_clk), .ATR_ARM(arm), .SESSION_READY(ready),
        .CARD_REJECTED(rejected));
    uva_card_model card (.clk_sys(clk_sys), .present(present), .slow(slow), .arm(arm),
        .card_class(card_class), .caps(caps), .mute(mute), .corrupt_n(corrupt_n),
        .atr_done(done), .atr_corrupt(corrupt), .atr_classes(atr_cls));
    initial forever #2 clk_sys = ~clk_sys;
    task automatic check(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Reference: highest index is the lowest voltage, a step up is index minus one
    task automatic predict();
        int cls = $clog2(int'(term) + 1) - 1;
        int cnt = 0, ncor = corrupt_n;
        bit bumped = 0, switched = 0, fin = (cls < 0);
        exp_q = {};
        exp_ready = 1'b0;
        while (!fin) begin
            exp_q.push_back(cls);
            if (mute[cls] || (ncor > 0 && cnt == 2)) begin
                fin = cls == 0 || !term[cls-1] || (!mute[cls] && bumped);
                bumped |= !mute[cls];
                ncor -= int'(!mute[cls]);
                cls--;
                cnt = 0;
            end else if (ncor > 0) begin
                ncor--;
                cnt++;
            end else if (!caps[cls]) begin
                fin = switched || !(term & caps);
                switched = 1;
                cnt = 0;
                cls = $clog2(int'(term & caps) + 1) - 1;
            end else
                {exp_ready, fin} = 2'b11;
        end
    endtask
    always @(posedge clk_sys) begin
        vcc_q <= vcc_en;
        if (vcc_en && !vcc_q)
            check(card_class === 5'(1 << exp_q.pop_front()), "class");
        if (++cycles == 90000) begin
            check(1'b0, "timeout");
            summarize();
        end
    end
    task automatic run_case(input logic [4:0] t, c, m, input int n);
        int k = 0;
        @(posedge clk_sys);
        term <= t;
        caps <= c;
        mute <= m;
        corrupt_n <= n;
        slow <= 1'($urandom);
        @(posedge clk_sys);
        predict();
        present <= 1'b1;
        while (ready !== 1'b1 && rejected !== 1'b1 && k++ < 20000)
            @(negedge clk_sys);
        check(ready === exp_ready && rejected === !exp_ready && !exp_q.size(), "outcome");
        check(ready === 1'b1 || vcc_en === 1'b0, "contacts left on");
        @(posedge clk_sys);
        present <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    initial begin
        int lo, hi;
        void'($urandom(90615));
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        run_case(5'h06, 5'h04, 5'h00, 0);
        run_case(5'h07, 5'h02, 5'h00, 0);
        run_case(5'h07, 5'h06, 5'h04, 0);
        run_case(5'h05, 5'h04, 5'h04, 0);
        run_case(5'h06, 5'h04, 5'h00, 2);
        run_case(5'h06, 5'h06, 5'h00, 3);
        run_case(5'h06, 5'h06, 5'h00, 6);
        run_case(5'h00, 5'h04, 5'h00, 0);
        for (int r = 0; r < 5; r++) begin
            lo = $urandom_range(4);
            hi = $urandom_range(4, lo);
            run_case(5'($urandom_range(31, 1)), 5'((1 << (hi + 1)) - (1 << lo)),
                5'($urandom), $urandom_range(4));
        end
        summarize();
    end
endmodule // tb_uva_sequencer
`default_nettype wire
